// ===== hw/pwm_pkg.sv
// Operation
// R01: Zero field gives fifty percent duty.
// R02: Duty linear with field, 8 to 92 percent.
// R03: Upward flux raises duty, downward lowers it.
// R04: Carrier runs at two kilohertz.
// R05: Capture timestamps on rising and falling edges.
// R06: Sampling tick much faster than carrier.
// R07: Duty is high over period, times 100.
// R08: Without capture, count ticks high and low.
// R09: Resolution step is carrier over tick, times 100.
// R10: Output invalid until power-on time elapses.
// R11: Single behaviour, no modes or configuration; the decoder has i_use_capture to choose capture or tick counting.
// R12: Flag lost signal; publish after full periods.
package pwm_pkg;
    // Clock and carrier timing.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CARRIER_HZ = 2_000;
    localparam int unsigned PERIOD_CYC = CLK_HZ / CARRIER_HZ;
    // Power-on time, longest figure, in microseconds.
    localparam int unsigned T_ON_US = 900;
    localparam int unsigned T_ON_CYC = T_ON_US * (CLK_HZ / 1_000_000);
    // Decoder sampling tick, far above the carrier.
    localparam int unsigned SAMPLE_HZ = 2_000_000;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    // Duty step in per-mille: carrier over tick times 1000.
    localparam int unsigned RES_PM = CARRIER_HZ * 1000 / SAMPLE_HZ;
    // Silence longer than this many carrier periods means lost signal.
    localparam int unsigned LOST_PERIODS = 4;
    localparam int unsigned LOST_CYC = PERIOD_CYC * LOST_PERIODS;
    // Widths.
    localparam int unsigned CNT_W = 24;
    localparam int unsigned IV_W = 16;
    localparam int unsigned PM_W = 10;
    localparam int unsigned FIELD_W = 11;
    localparam int unsigned NUM_W = IV_W + PM_W;
    // Duty values in per-mille of the period.
    localparam logic [PM_W-1:0] PM_FULL = 10'h3e8;
    localparam logic [PM_W-1:0] DUTY_ZERO_PM = 10'h1f4;
    localparam logic [PM_W-1:0] LIN_LO_PM = 10'h050;
    localparam logic [PM_W-1:0] LIN_HI_PM = 10'h398;
    localparam logic [PM_W-1:0] CLAMP_LO_PM = 10'h03c;
    localparam logic [PM_W-1:0] CLAMP_HI_PM = 10'h3ac;
endpackage

// ===== hw/pwm_link_if.sv
// Open-drain pulse-width line with a pull-up: released reads high.
interface pwm_link_if;
    logic pin_o;
    logic pin_oe;
    logic pin;

    // The pull-up wins unless the sensor sinks the line.
    assign pin = pin_oe ? pin_o : 1'b1;

    modport sensor (output pin_o, output pin_oe);
    modport decoder (input pin);
endinterface

// ===== hw/sync2.sv
// Two-flop synchroniser for a level arriving from a pin.
module sync2 (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_d,
    output logic o_q
);
    logic meta_q;
    logic sync_q;

    // Resets high to match an idle, pulled-up line.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

// ===== hw/hall_pwm_sensor.sv
// Sensor end: turns a signed field reading into an open-drain carrier.
module hall_pwm_sensor #(
    parameter int unsigned PERIOD_CYCLES = pwm_pkg::PERIOD_CYC,
    parameter int unsigned INIT_CYCLES = pwm_pkg::T_ON_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic signed [pwm_pkg::FIELD_W-1:0] i_field,
    pwm_link_if.sensor link,
    output logic o_ready
);
    import pwm_pkg::*;

    // Field in per-mille of duty, positive for upward flux.
    function automatic logic [PM_W-1:0] duty_of(
        input logic signed [FIELD_W-1:0] field
    );
        logic signed [FIELD_W+1:0] sum;
        // Every operand is signed, so a negative field extends its sign.
        sum = $signed({2'b00, DUTY_ZERO_PM}) + field; // R01 R03
        if (sum < $signed({3'b000, LIN_LO_PM})) begin
            duty_of = CLAMP_LO_PM; // R02
        end else if (sum > $signed({3'b000, LIN_HI_PM})) begin
            duty_of = CLAMP_HI_PM; // R02
        end else begin
            duty_of = sum[PM_W-1:0]; // R02
        end
    endfunction

    logic [CNT_W-1:0] init_q;
    logic ready_q;
    logic [CNT_W-1:0] phase_q;
    logic [CNT_W-1:0] high_q;
    logic [CNT_W-1:0] high_d;
    logic [31:0] high_prod;
    logic period_end;
    logic drive_low_q;

    // Only one behaviour exists: there is no mode pin to select. R11
    assign period_end = (phase_q == CNT_W'(PERIOD_CYCLES - 1)); // R04
    assign high_prod = PERIOD_CYCLES * 32'(duty_of(i_field));
    assign high_d = CNT_W'(high_prod / 32'(PM_FULL)); // R02

    // Power-on wait; the line is held low and meaningless until it ends.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            init_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            init_q <= init_q + 1'b1;
            ready_q <= (init_q == CNT_W'(INIT_CYCLES - 1)); // R10
        end
    end

    // Carrier phase; the new duty is taken once per period so each
    // period is whole, at the cost of one period of latency.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_q <= '0;
            high_q <= '0;
        end else if (!ready_q || period_end) begin
            phase_q <= '0; // R04
            high_q <= high_d;
        end else begin
            phase_q <= phase_q + 1'b1;
        end
    end

    // Sink the line during the low part and throughout initialisation.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drive_low_q <= 1'b1;
        end else begin
            drive_low_q <= !ready_q || (phase_q >= high_q); // R10
        end
    end

    assign link.pin_o = 1'b0;
    assign link.pin_oe = drive_low_q;
    assign o_ready = ready_q;
endmodule

// ===== hw/hall_pwm_decoder.sv
// Decoder end: measures high and low intervals of the carrier and
// publishes the duty in per-mille after each complete period.
module hall_pwm_decoder #(
    parameter int unsigned INIT_CYCLES = pwm_pkg::T_ON_CYC,
    parameter int unsigned LOST_CYCLES = pwm_pkg::LOST_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_use_capture,
    pwm_link_if.decoder link,
    output logic [pwm_pkg::PM_W-1:0] o_duty_pm,
    output logic [pwm_pkg::IV_W-1:0] o_high_interval,
    output logic [pwm_pkg::IV_W-1:0] o_low_interval,
    output logic o_valid,
    output logic o_in_range,
    output logic o_lost
);
    import pwm_pkg::*;

    typedef enum logic [1:0] {
        DIV_IDLE,
        DIV_RUN,
        DIV_DONE
    } div_state_t;

    // Saturating increment keeps a stuck line from wrapping a count.
    function automatic logic [IV_W-1:0] sat_inc(input logic [IV_W-1:0] v);
        sat_inc = (v == '1) ? v : v + 1'b1;
    endfunction

    logic pin_s;
    logic pin_d_q;
    logic rise;
    logic fall;
    logic edge_seen;
    logic [7:0] div_q;
    logic tick;
    logic [CNT_W-1:0] init_q;
    logic armed_q;
    logic [IV_W-1:0] ts_q;
    logic [IV_W-1:0] rise_ts_q;
    logic [IV_W-1:0] fall_ts_q;
    logic [IV_W-1:0] hcnt_q;
    logic [IV_W-1:0] lcnt_q;
    logic [IV_W-1:0] high_meas;
    logic [IV_W-1:0] low_meas;
    logic [IV_W-1:0] hi_iv_q;
    logic have_rise_q;
    logic have_high_q;
    logic [CNT_W-1:0] quiet_q;
    logic lost_q;
    logic period_done;
    div_state_t st_q;
    logic [NUM_W-1:0] num_q;
    logic [IV_W:0] den_q;
    logic [IV_W+1:0] rem_q;
    logic [NUM_W-1:0] quo_q;
    logic [4:0] step_q;
    logic [IV_W+1:0] rem_sh;
    logic rem_ge;
    logic [IV_W:0] den_sum;
    logic [NUM_W-1:0] num_load;
    logic [PM_W-1:0] duty_q;
    logic [IV_W-1:0] lo_iv_q;
    logic valid_q;
    logic range_q;

    // The pin is asynchronous to this clock, so it is synchronised first.
    sync2 u_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_d(link.pin),
        .o_q(pin_s)
    );

    // Edge detection looks only at the synchronised copy.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_d_q <= 1'b1;
        end else begin
            pin_d_q <= pin_s;
        end
    end

    assign rise = pin_s && !pin_d_q; // R05
    assign fall = !pin_s && pin_d_q; // R05
    assign edge_seen = rise || fall;

    // Sampling tick, a thousand times the carrier, sets the step. R06 R09
    assign tick = (div_q == 8'(SAMPLE_DIV - 1));

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Ignore the line until the sensor's power-on time has passed.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            init_q <= '0;
            armed_q <= 1'b0;
        end else if (!armed_q) begin
            init_q <= init_q + 1'b1;
            armed_q <= (init_q == CNT_W'(INIT_CYCLES - 1)); // R10
        end
    end

    // Free-running timestamp for the capture method; it wraps, and the
    // modular difference is right while an interval stays below the wrap.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ts_q <= '0;
            rise_ts_q <= '0;
            fall_ts_q <= '0;
        end else begin
            if (tick) begin
                ts_q <= ts_q + 1'b1;
            end
            if (rise) begin
                rise_ts_q <= ts_q; // R05
            end
            if (fall) begin
                fall_ts_q <= ts_q; // R05
            end
        end
    end

    // Tick counting for the method without capture; an edge restarts the
    // count of the level that begins.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hcnt_q <= '0;
            lcnt_q <= '0;
        end else begin
            if (rise) begin
                hcnt_q <= '0;
            end else if (tick && pin_s) begin
                hcnt_q <= sat_inc(hcnt_q); // R08
            end
            if (fall) begin
                lcnt_q <= '0;
            end else if (tick && !pin_s) begin
                lcnt_q <= sat_inc(lcnt_q); // R08
            end
        end
    end

    // Interval just ended, by whichever method is selected.
    assign high_meas = i_use_capture ? (ts_q - rise_ts_q) : hcnt_q; // R05 R08
    assign low_meas = i_use_capture ? (ts_q - fall_ts_q) : lcnt_q; // R05 R08

    // A period is complete at a rise that follows a measured high part.
    assign period_done = rise && have_high_q && armed_q; // R12

    // Period tracking and lost-signal watch. Silence of several carrier
    // periods sets the flag; any edge clears it, and the partial period
    // around the gap is discarded.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            have_rise_q <= 1'b0;
            have_high_q <= 1'b0;
            hi_iv_q <= '0;
            quiet_q <= '0;
            lost_q <= 1'b0;
        end else if (!armed_q) begin
            have_rise_q <= 1'b0; // R10
            have_high_q <= 1'b0; // R10
            quiet_q <= '0;
        end else if (edge_seen) begin
            quiet_q <= '0;
            lost_q <= 1'b0; // R12
            if (rise) begin
                have_rise_q <= 1'b1;
                have_high_q <= 1'b0;
            end else if (have_rise_q) begin
                hi_iv_q <= high_meas;
                have_high_q <= 1'b1;
            end
        end else if (quiet_q >= CNT_W'(LOST_CYCLES - 1)) begin
            lost_q <= 1'b1; // R12
            have_rise_q <= 1'b0;
            have_high_q <= 1'b0;
        end else begin
            quiet_q <= quiet_q + 1'b1;
        end
    end

    // Serial restoring divider: duty = high * 1000 / (high + low).
    // Trading speed for area is safe, as it ends long before the
    // next period can.
    assign den_sum = {1'b0, hi_iv_q} + {1'b0, low_meas}; // R07
    assign num_load = NUM_W'(hi_iv_q) * NUM_W'(PM_FULL); // R07
    assign rem_sh = {rem_q[IV_W:0], num_q[NUM_W-1]};
    assign rem_ge = (rem_sh >= {1'b0, den_q});

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= DIV_IDLE;
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            quo_q <= '0;
            step_q <= '0;
            lo_iv_q <= '0;
        end else begin
            case (st_q)
                DIV_IDLE: begin
                    if (period_done && den_sum != '0) begin
                        num_q <= num_load; // R07
                        den_q <= den_sum; // R07
                        lo_iv_q <= low_meas;
                        rem_q <= '0;
                        quo_q <= '0;
                        step_q <= '0;
                        st_q <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    num_q <= {num_q[NUM_W-2:0], 1'b0};
                    rem_q <= rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
                    quo_q <= {quo_q[NUM_W-2:0], rem_ge};
                    step_q <= step_q + 1'b1;
                    if (step_q == 5'(NUM_W - 1)) begin
                        st_q <= DIV_DONE;
                    end
                end
                DIV_DONE: begin
                    st_q <= DIV_IDLE;
                end
                default: begin
                    st_q <= DIV_IDLE;
                end
            endcase
        end
    end

    // Publish once per complete period, with a one-cycle valid strobe.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty_q <= '0;
            valid_q <= 1'b0;
            range_q <= 1'b0;
        end else begin
            valid_q <= (st_q == DIV_DONE); // R12
            if (st_q == DIV_DONE) begin
                duty_q <= quo_q[PM_W-1:0]; // R07
                range_q <= (quo_q[PM_W-1:0] >= LIN_LO_PM) &&
                           (quo_q[PM_W-1:0] <= LIN_HI_PM); // R02
            end
        end
    end

    assign o_duty_pm = duty_q;
    assign o_high_interval = hi_iv_q;
    assign o_low_interval = lo_iv_q;
    assign o_valid = valid_q;
    assign o_in_range = range_q;
    assign o_lost = lost_q;
endmodule

// ===== verif/hall_pwm_monitor.sv
// Watches the main link and the decoder that reads it.
module hall_pwm_monitor
#(
    parameter int unsigned PERIOD_CYCLES = pwm_pkg::PERIOD_CYC
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_pin_oe,
    input wire logic i_pin,
    input wire logic i_ready,
    input wire logic i_use_capture,
    input wire logic [pwm_pkg::PM_W-1:0] i_duty_pm,
    input wire logic [pwm_pkg::IV_W-1:0] i_high_interval,
    input wire logic [pwm_pkg::IV_W-1:0] i_low_interval,
    input wire logic i_valid,
    input wire logic i_in_range,
    input wire logic i_lost
);
    import pwm_pkg::*;
    logic pin_q;
    logic [1:0] rises_q;
    logic [15:0] gap_q;
    logic rise_w;
    logic [31:0] sum_w, prod_w, ref_w;

    // Cross products avoid a divider when checking the duty ratio.
    assign rise_w = i_pin & ~pin_q;
    assign sum_w = 32'(i_high_interval) + 32'(i_low_interval);
    assign prod_w = 32'(i_duty_pm) * sum_w;
    assign ref_w = 32'(i_high_interval) * 32'(PM_FULL);

    // The rise count saturates, so it never wraps back to a first period.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_q <= 1'b1;
            rises_q <= 2'h0;
            gap_q <= 16'h0;
        end else begin
            pin_q <= i_pin;
            gap_q <= rise_w ? 16'h0 : gap_q + 16'h1;
            if (rise_w && rises_q != 2'h3) begin
                rises_q <= rises_q + 2'h1;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    init_low_a: assert property (!i_ready |-> i_pin_oe && !i_pin)
        else $error("line released before power-on time");
    carrier_period_a: assert property (rise_w && rises_q != 2'h0 |->
        gap_q == PERIOD_CYCLES - 1) else $error("carrier period wrong");
    result_order_a: assert property (i_valid |-> rises_q >= 2'h2)
        else $error("result before a full period");
    result_delay_a: assert property (rise_w && rises_q >= 2'h2 |->
        ##[28:34] i_valid) else $error("result missing after period");
    valid_pulse_a: assert property (i_valid |=> !i_valid)
        else $error("result strobe too long");
    duty_hold_a: assert property (!i_valid |->
        $stable(i_duty_pm) && $stable(i_in_range))
        else $error("duty changed without strobe");
    range_flag_a: assert property (i_valid |-> i_in_range ==
        (i_duty_pm >= LIN_LO_PM && i_duty_pm <= LIN_HI_PM))
        else $error("range flag wrong");
    duty_ratio_a: assert property (i_valid |-> sum_w != 0 &&
        prod_w <= ref_w + sum_w && ref_w < prod_w + 2 * sum_w)
        else $error("duty not high over period");
    tick_count_a: assert property (i_valid |->
        sum_w + 1 >= PERIOD_CYCLES / SAMPLE_DIV &&
        sum_w <= PERIOD_CYCLES / SAMPLE_DIV + 1)
        else $error("period tick count wrong");
    no_loss_a: assert property (i_ready |-> !i_lost)
        else $error("lost flag on a live carrier");

    cover property (i_valid && i_in_range && i_use_capture);
    cover property (i_valid && i_in_range && !i_use_capture);
    cover property (i_valid && !i_in_range);
endmodule

// ===== verif/hall_pwm_duty_decoder_tb.sv
// Sensor and decoder face each other; a second decoder meets a stub line.
module hall_pwm_duty_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_pkg::*;
    // Short carrier and power-on counts keep the run brief.
    localparam int unsigned PER = 4000;
    localparam int unsigned INIT = 50;
    localparam int unsigned LOST = 10000;
    localparam int unsigned TICKS = PER / SAMPLE_DIV;
    logic i_mclk, i_arst_n, ready, use_cap, valid, in_rng, lost;
    logic s_valid, s_lost;
    logic signed [FIELD_W-1:0] field;
    logic [PM_W-1:0] duty;
    logic [IV_W-1:0] hi, lo;
    int errors, total_checks, s_count;

    pwm_link_if link_main ();
    pwm_link_if link_stub ();

    hall_pwm_sensor #(.PERIOD_CYCLES(PER), .INIT_CYCLES(INIT))
    hall_pwm_sensor_inst (.i_mclk, .i_arst_n, .i_field(field),
        .link(link_main), .o_ready(ready));
    hall_pwm_decoder #(.INIT_CYCLES(INIT), .LOST_CYCLES(LOST))
    hall_pwm_decoder_inst (.i_mclk, .i_arst_n, .i_use_capture(use_cap),
        .link(link_main), .o_duty_pm(duty), .o_high_interval(hi),
        .o_low_interval(lo), .o_valid(valid), .o_in_range(in_rng),
        .o_lost(lost));
    hall_pwm_decoder #(.INIT_CYCLES(INIT), .LOST_CYCLES(LOST))
    hall_pwm_decoder_fault_inst (.i_mclk, .i_arst_n,
        .i_use_capture(use_cap), .link(link_stub), .o_duty_pm(),
        .o_high_interval(), .o_low_interval(), .o_valid(s_valid),
        .o_in_range(), .o_lost(s_lost));
    hall_pwm_monitor #(.PERIOD_CYCLES(PER)) hall_pwm_monitor_inst (
        .i_mclk, .i_arst_n, .i_pin_oe(link_main.pin_oe),
        .i_pin(link_main.pin), .i_ready(ready), .i_use_capture(use_cap),
        .i_duty_pm(duty), .i_high_interval(hi), .i_low_interval(lo),
        .i_valid(valid), .i_in_range(in_rng), .i_lost(lost));

    // Clock and a count of results from the stub-side decoder.
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        if (s_valid === 1'b1) begin
            s_count <= s_count + 1;
        end
    end

    task chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask

    task wait_valid(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 2 * PER && !seen; i++) begin
            @(negedge i_mclk);
            seen = (valid === 1'b1);
        end
    endtask

    // Field changes just after a result, so the period after next is clean.
    task run_duty(input logic [FIELD_W-1:0] f, input logic cap, input int e);
        logic seen;
        int he;
        he = e * PER / 1000 / SAMPLE_DIV;
        wait_valid(seen);
        field = f;
        use_cap = cap;
        wait_valid(seen);
        wait_valid(seen);
        chk(seen, "no duty result");
        chk(duty + 15 >= e && duty <= e + 15, "duty wrong");
        chk(in_rng === (e >= 80 && e <= 920), "range flag wrong");
        chk(hi + lo + 1 >= TICKS && hi + lo <= TICKS + 1,
            "tick sum wrong");
        chk(hi + 1 >= he && hi <= he + 1, "high interval wrong");
    endtask

    task power_on;
        chk(link_main.pin === 1'b0 && ready === 1'b0, "early output");
        repeat (INIT + 5) @(negedge i_mclk);
        chk(ready === 1'b1, "sensor never ready");
    endtask

    task zero_field_capture;
        run_duty(11'h000, 1'b1, 500);
    endtask

    task upward_tick;
        run_duty(11'h12c, 1'b0, 800);
    endtask

    task downward_capture;
        run_duty(11'h6d4, 1'b1, 200);
    endtask

    task clamp_limits;
        run_duty(11'h1c2, 1'b0, 940);
        run_duty(11'h620, 1'b1, 60);
    endtask

    // Stub line: three periods, then released high and left silent.
    task lost_and_recover;
        int c0;
        repeat (3) begin
            link_stub.pin_oe = 1'b0;
            repeat (PER / 2) @(negedge i_mclk);
            link_stub.pin_oe = 1'b1;
            repeat (PER / 2) @(negedge i_mclk);
        end
        link_stub.pin_oe = 1'b0;
        repeat (40) @(negedge i_mclk);
        c0 = s_count;
        chk(c0 >= 1 && s_lost === 1'b0, "stub carrier not decoded");
        repeat (LOST - 50) @(negedge i_mclk);
        chk(s_lost === 1'b0, "lost flag too early");
        repeat (70) @(negedge i_mclk);
        chk(s_lost === 1'b1, "lost flag missing");
        chk(s_count == c0, "result while silent");
        link_stub.pin_oe = 1'b1;
        repeat (8) @(negedge i_mclk);
        chk(s_lost === 1'b0, "lost flag stuck");
    endtask

    task tally_and_finish;
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios in order.
    initial begin
        i_mclk = 1'b0;
        i_arst_n = 1'b0;
        field = 11'h000;
        use_cap = 1'b1;
        errors = 0;
        total_checks = 0;
        s_count = 0;
        link_stub.pin_o = 1'b0;
        link_stub.pin_oe = 1'b1;
        repeat (3) @(negedge i_mclk);
        i_arst_n = 1'b1;
        power_on();
        zero_field_capture();
        upward_tick();
        downward_capture();
        clamp_limits();
        lost_and_recover();
        tally_and_finish();
    end

    // The scenarios need about 82k cycles; this cuts a hang short while
    // keeping the whole run under 100k cycles.
    initial begin
        #950_000;
        errors++;
        $display("ERROR %0t: run did not finish", $time);
        tally_and_finish();
    end
endmodule
